// ==== design/acb_dev.sv ====
`include "acb_cfg.svh"
// Operation
// - Error register valid on error or diagnostics
// - Host writes feature only when idle
// - Feature read harmless; applies at command, but no command here uses feat_r
// - Diagnostic code after reset or diagnostics
// - Register-driven error bit layout
// - Media change rejects first command once
// - Removal request fails door lock commands
// - Aborted flag on invalid command
// - Track zero and address mark faults
// - Packet error layout with sense key
// - Sense key encoding table
// - Bad packet parameter gives illegal request
// - Feature value is command parameter; feat_r is latched but no command here uses it
// - Host accesses count/number only when idle
// - Zero sector count means 256
// - Count reads zero or sectors remaining
// - Packet register two is interrupt reason
// - Phase coding by direction, request, type
// - Release bit when bus freed early
// - Register three holds sector or address
// - Error updates register three address
// - Register six bit six selects addressing
// - Command write starts execution
module acb_dev
    import acb_pkg::*;
(
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    // Register bus to host
    acb_if.dev                    BUS,
    // Device personality and events
    input  wire logic             PACKET_MODE,
    input  wire logic             MEDIA_CHANGE,
    input  wire logic             REMOVAL_REQ,
    input  wire logic [3:0]       FAULT,
    input  wire logic             RELEASE_BUS,
    // Observed state
    output logic [7:0]            CMD_OUT,
    output logic                  LBA_MODE
);
    import acb_pkg::*;
    // ****************************************
    // Input synchronisers and strobes
    // ****************************************
    logic [2:0] rd_s_r, wr_s_r, rs_s_r;
    logic [1:0] mc_s_r, mr_s_r, rel_s_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_s_r <= 3'h0; wr_s_r <= 3'h0; rs_s_r <= 3'h7;
            mc_s_r <= 2'h0; mr_s_r <= 2'h0; rel_s_r <= 2'h0;
        end else begin
            rd_s_r  <= {rd_s_r[1:0], BUS.rd_stb};
            wr_s_r  <= {wr_s_r[1:0], BUS.wr_stb};
            rs_s_r  <= {rs_s_r[1:0], BUS.rst_n};
            mc_s_r  <= {mc_s_r[0], MEDIA_CHANGE};
            mr_s_r  <= {mr_s_r[0], REMOVAL_REQ};
            rel_s_r <= {rel_s_r[0], RELEASE_BUS};
        end
    end
    logic wr_ev, hard_rst;
    assign wr_ev    = wr_s_r[1] & ~wr_s_r[2];
    assign hard_rst = ~rs_s_r[1];
    logic unused_rd;
    assign unused_rd = rd_s_r[2]; // Reads have no side effect
    // ****************************************
    // Host parameter registers
    // ****************************************
    logic [7:0] feat_r, cnt_r, secn_r, head_r, cmd_r;
    logic       busy_r, drq_r, err_r, diag_r;
    logic       go_r;
    logic       mdone, mfail;
    logic [7:0] mleft, msec;
    // Held until rewritten or updated by completion
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            feat_r <= 8'h00; cnt_r <= 8'h00; secn_r <= 8'h00;
            head_r <= 8'h00; cmd_r <= 8'h00; go_r <= 1'b0;
        end else begin
            go_r <= 1'b0;
            if (wr_ev && !busy_r) begin
                case (BUS.addr)
                    `ACB_ADDR_ERRFEAT: feat_r <= BUS.wdata;
                    `ACB_ADDR_SECCNT:  cnt_r  <= BUS.wdata;
                    `ACB_ADDR_SECNUM:  secn_r <= BUS.wdata;
                    `ACB_ADDR_HEAD:    head_r <= BUS.wdata;
                    `ACB_ADDR_CMD: begin
                        cmd_r <= BUS.wdata;
                        go_r  <= 1'b1;
                    end
                    default: ;
                endcase
            end else if (mdone) begin
                cnt_r <= mfail ? mleft : 8'h00;
                if (mfail) secn_r <= msec;
            end
        end
    end
    // ****************************************
    // Command execution and error status
    // ****************************************
    logic       mc_pend_r, mcr_r, aborted_flag_r, unc_r, id_missing_flag_r, tk0_r, address_mark_missing_flag_r, eom_r, ili_r;
    logic [3:0] sense_r;
    logic       media_cmd, latched_feat_unused;
    assign media_cmd = (cmd_r == `ACB_CMD_READ) || (cmd_r == `ACB_CMD_WRITE);
    assign latched_feat_unused = ^feat_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_r <= 1'b0; drq_r <= 1'b0; err_r <= 1'b0; diag_r <= 1'b1;
            mc_pend_r <= 1'b0; mcr_r <= 1'b0; aborted_flag_r <= 1'b0; unc_r <= 1'b0;
            id_missing_flag_r <= 1'b0; tk0_r <= 1'b0; address_mark_missing_flag_r <= 1'b0; eom_r <= 1'b0;
            ili_r <= 1'b0; sense_r <= `ACB_SK_NONE;
        end else if (hard_rst) begin
            busy_r <= 1'b0; drq_r <= 1'b0; err_r <= 1'b0; diag_r <= 1'b1;
            mc_pend_r <= 1'b0; mcr_r <= 1'b0;
        end else begin
            if (mc_s_r[1]) mc_pend_r <= 1'b1; // set wins over clear
            if (mr_s_r[1]) mcr_r <= 1'b1;
            if (go_r) begin
                diag_r <= 1'b0; err_r <= 1'b0; aborted_flag_r <= 1'b0; unc_r <= 1'b0;
                id_missing_flag_r <= 1'b0; tk0_r <= 1'b0; address_mark_missing_flag_r <= 1'b0;
                eom_r <= 1'b0; ili_r <= 1'b0; sense_r <= `ACB_SK_NONE;
                if (mc_pend_r) begin
                    mc_pend_r <= mc_s_r[1];
                    err_r     <= 1'b1;
                    sense_r   <= `ACB_SK_UNIT_ATTN;
                end else begin
                    case (cmd_r)
                        `ACB_CMD_READ, `ACB_CMD_WRITE: busy_r <= 1'b1;
                        `ACB_CMD_DIAG: diag_r <= 1'b1;
                        `ACB_CMD_RECAL: begin
                            tk0_r <= FAULT[2];
                            err_r <= FAULT[2];
                        end
                        `ACB_CMD_LOCK: begin
                            err_r <= mcr_r;
                        end
                        `ACB_CMD_UNLOCK, `ACB_CMD_EJECT: begin
                            if (!mr_s_r[1]) mcr_r <= 1'b0;
                        end
                        `ACB_CMD_PACKET: begin
                            if (FAULT[3]) begin
                                err_r   <= 1'b1;
                                aborted_flag_r  <= 1'b1;
                                sense_r <= `ACB_SK_ILLEGAL;
                            end
                        end
                        default: begin
                            aborted_flag_r  <= 1'b1;
                            err_r   <= 1'b1;
                            sense_r <= `ACB_SK_ABORTED;
                        end
                    endcase
                end
            end else if (mdone) begin
                busy_r <= 1'b0;
                err_r  <= mfail;
                address_mark_missing_flag_r <= mfail & FAULT[1];
                unc_r  <= mfail & ~FAULT[1];
                sense_r <= mfail ? `ACB_SK_MEDIUM : `ACB_SK_NONE;
            end
        end
    end
    // ****************************************
    // Read data and status, one register stage
    // ****************************************
    logic [7:0] err_val, reason_val, rdata_r, stat_r;
    always_comb begin
        if (PACKET_MODE) err_val = {sense_r, mcr_r, aborted_flag_r, eom_r, ili_r};
        else err_val = {1'b0, unc_r, (sense_r == `ACB_SK_UNIT_ATTN), id_missing_flag_r, mcr_r & err_r,
                        aborted_flag_r, tk0_r, address_mark_missing_flag_r};
        if (diag_r) err_val = `ACB_DIAG_CODE;
        // Status phase shown when idle, else data to host
        reason_val = {5'h00, rel_s_r[1] & busy_r, 1'b1, ~busy_r};
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 8'h00;
            stat_r  <= 8'h00;
        end else begin
            stat_r <= {busy_r, 3'h0, drq_r, 2'h0, err_r};
            case (BUS.addr)
                `ACB_ADDR_ERRFEAT: rdata_r <= err_val;
                `ACB_ADDR_SECCNT:  rdata_r <= PACKET_MODE ? reason_val : cnt_r;
                `ACB_ADDR_SECNUM:  rdata_r <= secn_r;
                `ACB_ADDR_HEAD:    rdata_r <= head_r;
                `ACB_ADDR_CMD:     rdata_r <= {busy_r, 3'h0, drq_r, 2'h0, err_r};
                default:           rdata_r <= 8'h00;
            endcase
        end
    end
    assign BUS.rdata  = rdata_r;
    assign BUS.status = stat_r;
    // Observed outputs
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_OUT  <= 8'h00;
            LBA_MODE <= 1'b0;
        end else begin
            CMD_OUT  <= cmd_r;
            LBA_MODE <= head_r[`ACB_HEAD_LBA];
        end
    end
    // ****************************************
    // Media engine
    // ****************************************
    acb_media u_media (
        .clk         (CLK),
        .arst_n      (ARST_N),
        .start       (go_r & media_cmd & ~mc_pend_r),
        .cmd         (cmd_r),
        .count       (cnt_r),
        .sector      (secn_r),
        .fault       (FAULT[1:0]),
        .done        (mdone),
        .fail        (mfail),
        .left        (mleft),
        .fail_sector (msec)
    );
    logic unused_dev;
    assign unused_dev = latched_feat_unused ^ unused_rd ^ FAULT[0];
endmodule

// ==== design/acb_cfg.svh ====
`ifndef ACB_CFG_SVH
`define ACB_CFG_SVH
// Register addresses on the parallel bus (DA field, command block)
`define ACB_ADDR_DATA     3'h0
`define ACB_ADDR_ERRFEAT  3'h1
`define ACB_ADDR_SECCNT   3'h2
`define ACB_ADDR_SECNUM   3'h3
`define ACB_ADDR_HEAD     3'h6
`define ACB_ADDR_CMD      3'h7
// Error register bits, register-driven device
`define ACB_ERR_UNC       6
`define ACB_ERR_MC        5
`define ACB_ERR_ID_MISSING_FLAG      4
`define ACB_ERR_MCR       3
`define ACB_ERR_ABORTED_FLAG      2
`define ACB_ERR_TK0       1
`define ACB_ERR_ADDRESS_MARK_MISSING_FLAG      0
// Error register bits, packet device
`define ACB_ERR_EOM       1
`define ACB_ERR_ILI       0
// Interrupt reason bits
`define ACB_IR_COD        0
`define ACB_IR_IO         1
`define ACB_IR_REL        2
// Address mode bit in register six
`define ACB_HEAD_LBA      6
// Sense keys
`define ACB_SK_NONE       4'h0
`define ACB_SK_RECOVERED  4'h1
`define ACB_SK_NOT_READY  4'h2
`define ACB_SK_MEDIUM     4'h3
`define ACB_SK_HARDWARE   4'h4
`define ACB_SK_ILLEGAL    4'h5
`define ACB_SK_UNIT_ATTN  4'h6
`define ACB_SK_PROTECT    4'h7
`define ACB_SK_ABORTED    4'hb
`define ACB_SK_MISCOMPARE 4'he
// Diagnostic code after reset (value arbitrary)
`define ACB_DIAG_CODE     8'h01
// Command codes used by this block
`define ACB_CMD_RECAL     8'h10
`define ACB_CMD_READ      8'h20
`define ACB_CMD_WRITE     8'h30
`define ACB_CMD_DIAG      8'h90
`define ACB_CMD_PACKET    8'ha0
`define ACB_CMD_LOCK      8'hde
`define ACB_CMD_UNLOCK    8'hdf
`define ACB_CMD_EJECT     8'hed
// Host APB register offsets
`define ACB_APB_CTRL      12'h000
`define ACB_APB_ADDR      12'h004
`define ACB_APB_WDATA     12'h008
`define ACB_APB_RDATA     12'h00c
`define ACB_APB_STAT      12'h010
// Device status bits
`define ACB_ST_BUSY       7
`define ACB_ST_DRQ        3
`define ACB_ST_ERR        0
`endif

// ==== design/acb_pkg.sv ====
package acb_pkg;
    typedef enum logic [3:0] {
        ACB_IDLE  = 4'b0001,
        ACB_STROBE = 4'b0010,
        ACB_HOLD  = 4'b0100,
        ACB_DONE  = 4'b1000
    } acb_hstate_t;
    typedef logic [7:0] acb_byte_t;
    typedef logic [2:0] acb_addr_t;
endpackage

// ==== design/acb_if.sv ====
interface acb_if;
    logic       rd_stb;
    logic       wr_stb;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] status;
    logic       rst_n;
    modport dev  (input rd_stb, wr_stb, addr, wdata, rst_n, output rdata, status);
    modport host (output rd_stb, wr_stb, addr, wdata, rst_n, input rdata, status);
endinterface

// ==== design/acb_media.sv ====
`include "acb_cfg.svh"
// ****************************************
// Media engine: outcome of a read or write command
// ****************************************
module acb_media
    import acb_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // Command start and parameters
    input  wire logic            start,
    input  wire acb_pkg::acb_byte_t cmd,
    input  wire acb_pkg::acb_byte_t count,
    input  wire acb_pkg::acb_byte_t sector,
    // Fault injection from the user side
    input  wire logic [1:0]      fault,
    // Result
    output logic                 done,
    output logic                 fail,
    output acb_pkg::acb_byte_t   left,
    output acb_pkg::acb_byte_t   fail_sector
);
    logic [8:0] remain_r;
    logic [7:0] pos_r;
    logic       run_r;

    // Sector walk; zero count means 256 sectors
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remain_r <= 9'h000;
            pos_r    <= 8'h00;
            run_r    <= 1'b0;
            done     <= 1'b0;
            fail     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain_r <= (count == 8'h00) ? 9'h100 : {1'b0, count};
                pos_r    <= sector;
                run_r    <= 1'b1;
                fail     <= 1'b0;
            end else if (run_r) begin
                if (fault[0] && remain_r == 9'h001) begin
                    run_r <= 1'b0;
                    done  <= 1'b1;
                    fail  <= 1'b1;
                end else if (remain_r == 9'h001 || remain_r == 9'h000) begin
                    remain_r <= 9'h000;
                    run_r    <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    remain_r <= remain_r - 9'h001;
                    pos_r    <= pos_r + 8'h01;
                end
            end
        end
    end
    // Residue and error address
    assign left        = remain_r[7:0];
    assign fail_sector = pos_r;
    logic unused_ok;
    assign unused_ok = ^{cmd, fault[1], remain_r[8]};
endmodule

// ==== design/acb_host.sv ====
`include "acb_cfg.svh"
// APB-controlled host end; accesses only when device is idle
module acb_host
    import acb_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Register bus to device
    acb_if.host              BUS
);
    import acb_pkg::*;
    acb_hstate_t st_r;
    logic [2:0]  addr_r;
    logic [7:0]  wd_r, rd_r, stat_s1_r, stat_s2_r, rdat_s1_r, rdat_s2_r;
    logic        wr_r, rst_r, cmd_rd_r, cmd_wr_r, err_r;
    logic [3:0]  cnt_r;
    logic        apb_wr;
    assign apb_wr = PSEL & PENABLE & PWRITE & PREADY;
    // Status/data sync from device
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_s1_r <= 8'h00; stat_s2_r <= 8'h00;
            rdat_s1_r <= 8'h00; rdat_s2_r <= 8'h00;
        end else begin
            stat_s1_r <= BUS.status; stat_s2_r <= stat_s1_r;
            rdat_s1_r <= BUS.rdata;  rdat_s2_r <= rdat_s1_r;
        end
    end
    // APB registers and single-cycle answer
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_r <= 3'h0; wd_r <= 8'h00; rst_r <= 1'b0;
            cmd_rd_r <= 1'b0; cmd_wr_r <= 1'b0;
            PRDATA <= 32'h0; PREADY <= 1'b0; PSLVERR <= 1'b0;
        end else begin
            cmd_rd_r <= 1'b0; cmd_wr_r <= 1'b0;
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & PWRITE & (PADDR > `ACB_APB_WDATA);
            if (apb_wr) begin
                case (PADDR)
                    `ACB_APB_CTRL: begin
                        rst_r    <= PWDATA[2];
                        cmd_wr_r <= PWDATA[0] & PWDATA[1];
                        cmd_rd_r <= PWDATA[0] & ~PWDATA[1];
                    end
                    `ACB_APB_ADDR:  addr_r <= PWDATA[2:0];
                    `ACB_APB_WDATA: wd_r   <= PWDATA[7:0];
                    default: ;
                endcase
            end
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                    `ACB_APB_CTRL:  PRDATA <= {29'h0, rst_r, wr_r, 1'b0};
                    `ACB_APB_ADDR:  PRDATA <= {29'h0, addr_r};
                    `ACB_APB_WDATA: PRDATA <= {24'h0, wd_r};
                    `ACB_APB_RDATA: PRDATA <= {24'h0, rd_r};
                    `ACB_APB_STAT:  PRDATA <= {15'h0, err_r, 4'h0, st_r, stat_s2_r};
                    default:        PRDATA <= 32'h0;
                endcase
            end
        end
    end
    // Strobe sequencer; refuses access while busy or requesting data
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= ACB_IDLE; cnt_r <= 4'h0; rd_r <= 8'h00; err_r <= 1'b0; wr_r <= 1'b0;
        end else begin
            case (st_r)
                ACB_IDLE: if (cmd_rd_r || cmd_wr_r) begin
                    wr_r <= cmd_wr_r;
                    if (stat_s2_r[`ACB_ST_BUSY] || stat_s2_r[`ACB_ST_DRQ]) err_r <= 1'b1;
                    else begin
                        err_r <= 1'b0;
                        st_r  <= ACB_STROBE;
                        cnt_r <= 4'h0;
                    end
                end
                ACB_STROBE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h7) begin
                        st_r <= ACB_HOLD;
                        cnt_r <= 4'h0;
                        rd_r <= rdat_s2_r;
                    end
                end
                ACB_HOLD: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h7) st_r <= ACB_DONE;
                end
                ACB_DONE: st_r <= ACB_IDLE;
                default:  st_r <= ACB_IDLE;
            endcase
        end
    end
    assign BUS.rd_stb = (st_r == ACB_STROBE) & ~wr_r;
    assign BUS.wr_stb = (st_r == ACB_STROBE) & wr_r;
    assign BUS.addr   = addr_r;
    assign BUS.wdata  = wd_r;
    assign BUS.rst_n  = ~rst_r;
endmodule

// ==== tb/acb_chk.sv ====
// ****************************************
// Link checker between host and device ends
// ****************************************
module acb_chk (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       ARST_N,
    // Link signals
    input wire logic       rd_stb,
    input wire logic       wr_stb,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [7:0] status,
    input wire logic       rst_n
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Strobes never overlap, last eight cycles, and never start while the device is busy or wants data
    strobe_excl_a: assert property (!(rd_stb && wr_stb))
        else $error("read and write strobes overlap");
    idle_write_a: assert property ($rose(wr_stb) |-> !status[7] && !status[3])
        else $error("write strobe while busy or data request");
    idle_read_a: assert property ($rose(rd_stb) |-> !status[7] && !status[3])
        else $error("read strobe while busy or data request");
    wr_len_a: assert property ($rose(wr_stb) |-> wr_stb [*8])
        else $error("write strobe too short");
    rd_len_a: assert property ($rose(rd_stb) |-> rd_stb [*8])
        else $error("read strobe too short");
    // Parameters must not move under a write strobe
    param_hold_a: assert property (wr_stb && $past(wr_stb) |-> $stable(addr) && $stable(wdata))
        else $error("address or data moved during write");
    // Media command must make the device busy soon
    cmd_start_a: assert property ($rose(wr_stb) && addr == 3'h7
        && (wdata == 8'h20 || wdata == 8'h30) |-> ##[1:10] status[7])
        else $error("media command did not start");
    // Reading is side-effect free, so read data holds
    read_quiet_a: assert property (rd_stb && $past(rd_stb) && $past(rd_stb, 2)
        && !status[7] && !$past(status[7]) |-> $stable(rdata))
        else $error("read data changed during idle read");
    media_cmd_c: cover property ($rose(wr_stb) && addr == 3'h7 && wdata == 8'h20);
    err_read_c: cover property ($rose(rd_stb) && addr == 3'h1);
    busy_end_c: cover property ($fell(status[7]));
    hard_rst_c: cover property ($fell(rst_n));
endmodule

// ==== tb/acb_tb.sv ====
`include "acb_cfg.svh"
module acb_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, last_st;
    logic        pready, pslverr, lba_mode;
    logic        packet_mode = 0, media_change = 0, removal_req = 0;
    logic [3:0]  fault = 0;
    logic [7:0]  cmd_out;
    int          err_total = 0, num_checks = 0;
    // ****************************************
    // Ends, link and checker
    // ****************************************
    acb_if link();
    acb_host acb_host_inst (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BUS(link));
    // Bus release stays low: only visible while busy, when reads are barred
    acb_dev acb_dev_inst (.CLK(clk), .ARST_N(arst_n), .BUS(link), .PACKET_MODE(packet_mode),
        .MEDIA_CHANGE(media_change), .REMOVAL_REQ(removal_req), .FAULT(fault),
        .RELEASE_BUS(1'b0), .CMD_OUT(cmd_out), .LBA_MODE(lba_mode));
    acb_chk acb_chk_inst (.CLK(clk), .ARST_N(arst_n), .rd_stb(link.rd_stb),
        .wr_stb(link.wr_stb), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .status(link.status), .rst_n(link.rst_n));
    always #2.5 clk = ~clk;
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One link access; waits for host and device to settle
    task automatic dev(input logic w, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic e;
        int n;
        logic [31:0] r;
        apb(1, `ACB_APB_WDATA, {24'h0, d}, last_st, e);
        apb(1, `ACB_APB_ADDR, {29'h0, a}, last_st, e);
        apb(1, `ACB_APB_CTRL, {30'h0, w, 1'b1}, last_st, e);
        n = 0;
        do begin
            apb(0, `ACB_APB_STAT, 0, last_st, e);
            n++;
        end while ((last_st[11:8] !== 4'b0001 || last_st[7] !== 1'b0) && n < 300);
        if (n >= 300) err_total++;
        apb(0, `ACB_APB_RDATA, 0, r, e);
        q = r[7:0];
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] q;
        logic [31:0] r;
        logic e;
        dev(0, 3'h1, 8'h00, q);
        chk("diag code", `ACB_DIAG_CODE, q);
        dev(1, 3'h1, 8'h5a, q);
        dev(0, 3'h1, 8'h00, q);
        chk("error after feature", `ACB_DIAG_CODE, q);
        apb(1, 12'h040, 0, r, e);
        chk("unmapped write refused", 8'h01, {7'h0, e});
        apb(0, 12'h040, 0, r, e);
        chk("unmapped read", 8'h00, r[7:0]);
        $display("done: reset");
    endtask
    // Good read, failing read and write, zero count meaning 256
    task automatic t_media();
        logic [7:0] q, cnt, cmd;
        for (int i = 0; i < 4; i++) begin
            cnt = (i == 3) ? 8'h00 : 8'h04;
            cmd = (i == 2) ? `ACB_CMD_WRITE : `ACB_CMD_READ;
            fault <= (i == 0) ? 4'h0 : ((i == 2) ? 4'h3 : 4'h1);
            dev(1, 3'h2, cnt, q);
            dev(1, 3'h3, 8'h20, q);
            dev(1, 3'h7, cmd, q);
            chk("last command", cmd, cmd_out);
            chk("error flag", {7'h0, i != 0}, {7'h0, last_st[0]});
            dev(0, 3'h2, 8'h00, q);
            chk("count left", {7'h0, i != 0}, q);
            if (i != 0) begin
                dev(0, 3'h3, 8'h00, q);
                chk("fail address", 8'h1f + cnt, q);
                dev(0, 3'h1, 8'h00, q);
                chk("error bits", (i == 2) ? 8'h01 : 8'h40, q);
            end
        end
        fault <= 4'h0;
        $display("done: media");
    endtask
    // Failed recalibrate, then an unknown command code
    task automatic t_abort();
        logic [7:0] q;
        for (int i = 0; i < 2; i++) begin
            fault <= i ? 4'h0 : 4'h4;
            dev(1, 3'h7, i ? 8'h55 : `ACB_CMD_RECAL, q);
            chk("error flag", 8'h01, {7'h0, last_st[0]});
            dev(0, 3'h1, 8'h00, q);
            chk("error bits", i ? 8'h04 : 8'h02, q);
        end
        fault <= 4'h0;
        $display("done: abort");
    endtask
    // Media change, removal request and hard reset
    task automatic t_events();
        logic [7:0] q;
        logic [31:0] r;
        logic e;
        logic [7:0] cmds [6] = '{`ACB_CMD_RECAL, `ACB_CMD_RECAL, `ACB_CMD_LOCK,
                                 `ACB_CMD_LOCK, `ACB_CMD_UNLOCK, `ACB_CMD_LOCK};
        logic [7:0] bits [6] = '{8'h20, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            media_change <= (i == 0);
            removal_req <= (i == 2);
            repeat (8) @(posedge clk);
            media_change <= 1'b0;
            removal_req <= 1'b0;
            repeat (8) @(posedge clk);
            dev(1, 3'h7, cmds[i], q);
            chk("error flag", {7'h0, bits[i] != 0}, {7'h0, last_st[0]});
            dev(0, 3'h1, 8'h00, q);
            if (bits[i] != 0) chk("event bit", bits[i], q & bits[i]);
        end
        media_change <= 1'b1;
        removal_req <= 1'b1;
        repeat (8) @(posedge clk);
        media_change <= 1'b0;
        removal_req <= 1'b0;
        apb(1, `ACB_APB_CTRL, 32'h4, r, e);
        repeat (8) @(posedge clk);
        apb(1, `ACB_APB_CTRL, 32'h0, r, e);
        dev(1, 3'h7, `ACB_CMD_LOCK, q);
        chk("flags cleared by hard reset", 8'h00, {7'h0, last_st[0]});
        $display("done: events");
    endtask
    // Packet layouts: reason register and sense keys
    task automatic t_packet();
        logic [7:0] q;
        packet_mode <= 1'b1;
        dev(0, 3'h2, 8'h00, q);
        chk("status phase", 8'h05, {4'h0, q[2:1], last_st[3], q[0]});
        for (int i = 0; i < 2; i++) begin
            fault <= i ? 4'h0 : 4'h8;
            media_change <= (i == 1);
            repeat (8) @(posedge clk);
            media_change <= 1'b0;
            repeat (8) @(posedge clk);
            dev(1, 3'h7, `ACB_CMD_PACKET, q);
            dev(0, 3'h1, 8'h00, q);
            chk("sense key", i ? {4'h0, `ACB_SK_UNIT_ATTN} : {4'h0, `ACB_SK_ILLEGAL},
                {4'h0, q[7:4]});
        end
        fault <= 4'h0;
        packet_mode <= 1'b0;
        $display("done: packet");
    endtask
    // Address mode bit, diagnostics restore the code
    task automatic t_mode();
        logic [7:0] q;
        for (int i = 0; i < 2; i++) begin
            dev(1, 3'h6, i ? 8'h00 : 8'h40, q);
            dev(1, 3'h7, `ACB_CMD_DIAG, q);
            chk("address mode", {7'h0, i == 0}, {7'h0, lba_mode});
            dev(0, 3'h1, 8'h00, q);
            chk("diag code", `ACB_DIAG_CODE, q);
        end
        $display("done: mode");
    endtask
    // Watchdog against a hung handshake
    initial begin
        #400us;
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_media();
        t_abort();
        t_events();
        t_packet();
        t_mode();
        tally_and_finish();
    end
endmodule
